// >>> verification/pcsr_regs_properties.sv
// checker: bus timing and settings properties of the pll register slice
`default_nettype none
module pcsr_regs_properties
  import pcsr_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // settings
  input wire logic [4:0]  logic_clock_divide,
  input wire logic [2:0]  oscillator_divide,
  input wire logic [4:0]  loop_divide,
  input wire logic [9:0]  inphase_fullscale
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ans_pulse; (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o); endproperty
  a_ans_pulse: assert property (p_ans_pulse) else $error("answer longer than one cycle");
  property p_ans_cause; (wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ans_cause: assert property (p_ans_cause) else $error("answer without request");
  property p_ans_time; $rose(wb_cyc_i && wb_stb_i) |=> (wb_ack_o ^ wb_err_o); endproperty
  a_ans_time: assert property (p_ans_time) else $error("no single answer next cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_dat_byte; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_dat_byte: assert property (p_dat_byte) else $error("upper read bits set");
  property p_err_cause;
    wb_err_o |-> ($past(wb_adr_i[1:0]) != 2'b00 ||
                  !($past(wb_adr_i[9:2]) inside {8'h12, [8'h14:8'h19]}));
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error on a mapped address");
  // the code may only move because of a write in the last two cycles
  property p_fs_write;
    $changed(inphase_fullscale) |-> ($past(wb_we_i && wb_cyc_i) || $past(wb_we_i && wb_cyc_i, 2));
  endproperty
  a_fs_write: assert property (p_fs_write) else $error("full scale moved without write");
  property p_ratio;
    loop_divide inside {5'd2, 5'd4, 5'd8, 5'd16} && oscillator_divide inside {3'd1, 3'd2, 3'd4}
      && logic_clock_divide inside {5'd2, 5'd4, 5'd8, 5'd16};
  endproperty
  a_ratio: assert property (p_ratio) else $error("illegal divide ratio");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_err: cover property (wb_err_o);
  c_fs: cover property ($changed(inphase_fullscale));
endmodule
bind pcsr_regs pcsr_regs_properties pcsr_regs_properties_i (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .logic_clock_divide, .oscillator_divide,
  .loop_divide, .inphase_fullscale);
`default_nettype wire

// >>> verification/pcsr_regs_test.sv
// testbench: register access and readback scenarios for the pll register slice
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module pcsr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import pcsr_pkg::*;
  logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, pll_lock_raw;
  logic        pll_enable, manual_band_mode, crosspoint_enable, e;
  logic [9:0]  wb_adr_i, inphase_fullscale;
  logic [3:0]  wb_sel_i, tuning_voltage_raw;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0]  band_raw, manual_band;
  logic [2:0]  loop_filter_bandwidth, oscillator_divide;
  logic [4:0]  charge_pump_setting, logic_clock_divide, loop_divide;
  logic [7:0]  q;
  int          n_errors, samples_checked;
  pcsr_regs pcsr_regs_i (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one classic cycle; the answer is taken at the edge that samples it
  task automatic acc(input logic we, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] sel);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      finish_test();
    end
    q = wb_dat_o[7:0];
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00, 4'hF);
    `CHK($sformatf("reg %h", idx), exp, q)
    `CHK("read err", 1'b0, e)
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'hF);
    acc(1'b1, idx, d, sel);
    `CHK("write err", 1'b0, e)
  endtask
  initial begin
    int i;
    logic [2:0] osc;
    n_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    pll_lock_raw = 1'b1;
    tuning_voltage_raw = 4'h7;
    band_raw = 6'h2A;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    `CHK("bw", 3'h7, loop_filter_bandwidth)
    `CHK("cp", 5'h07, charge_pump_setting)
    `CHK("fs", 10'h1F9, inphase_fullscale)
    `CHK("enable", 1'b0, pll_enable)
    rd(8'h14, 8'hE7);
    rd(8'h15, 8'hC9);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h18, 8'hF9);
    rd(8'h19, 8'hE1);
    wr(8'h14, 8'h1A);
    wr(8'h14, 8'h00, 4'hE);
    rd(8'h14, 8'h1A);
    `CHK("bw", 3'h0, loop_filter_bandwidth)
    `CHK("cp", 5'h1A, charge_pump_setting)
    for (i = 0; i < 4; i++) begin
      wr(8'h15, {i[1:0], 1'b0, i[0], i[1:0], i[1:0]});
      rd(8'h15, {i[1:0], 1'b0, i[0], i[1:0], i[1:0]});
      osc = (i == 0) ? 3'd1 : (i == 1) ? 3'd2 : 3'd4;
      `CHK("logic div", 5'd2 << i, logic_clock_divide)
      `CHK("xpt", i[0], crosspoint_enable)
      `CHK("osc div", osc, oscillator_divide)
      `CHK("loop div", 5'd2 << i, loop_divide)
    end
    wr(8'h18, 8'h23);
    wr(8'h19, 8'hFE);
    rd(8'h19, 8'hFE);
    `CHK("fs", 10'h223, inphase_fullscale)
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h00);
    acc(1'b0, 8'h30, 8'h00, 4'hF);
    `CHK("unmapped err", 1'b1, e)
    wr(8'h12, 8'hC5);
    repeat (5) @(posedge clk);
    `CHK("enable", 1'b1, pll_enable)
    `CHK("manual", 1'b1, manual_band_mode)
    `CHK("band sel", 6'h05, manual_band)
    rd(8'h16, 8'h87);
    rd(8'h17, 8'h2A);
    band_raw <= 6'h30;
    tuning_voltage_raw <= 4'h3;
    repeat (5) @(posedge clk);
    rd(8'h16, 8'h83);
    rd(8'h17, 8'h30);
    // too soon for the synchroniser to pass the drop of lock
    pll_lock_raw <= 1'b0;
    rd(8'h16, 8'h83);
    repeat (5) @(posedge clk);
    rd(8'h16, 8'h03);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h18, 8'hF9);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> verilog/pcsr_pkg.sv
// package: register map, field layout and reset values of the pll register slice
`default_nettype none
package pcsr_pkg;
  // register indices (word indices on the wishbone bus; the byte address is index * 4)
  localparam logic [7:0] PCSR_IDX_LOOP     = 8'h14;
  localparam logic [7:0] PCSR_IDX_DIV      = 8'h15;
  localparam logic [7:0] PCSR_IDX_LOCK     = 8'h16;
  localparam logic [7:0] PCSR_IDX_BAND     = 8'h17;
  localparam logic [7:0] PCSR_IDX_FS_LOW   = 8'h18;
  localparam logic [7:0] PCSR_IDX_FS_HIGH  = 8'h19;
  localparam logic [7:0] PCSR_IDX_CTRL     = 8'h12;
  localparam int         PCSR_ADDR_W       = 8;
  // reset values
  localparam logic [7:0] PCSR_RST_LOOP     = 8'hE7;
  localparam logic [7:0] PCSR_RST_DIV      = 8'hC9;
  localparam logic [7:0] PCSR_RST_FS_LOW   = 8'hF9;
  localparam logic [7:0] PCSR_RST_FS_HIGH  = 8'hE1;
  localparam logic [7:0] PCSR_RST_CTRL     = 8'h00;
  localparam logic [7:0] PCSR_RST_STATUS   = 8'h00;
  // field positions
  localparam int PCSR_BW_LSB      = 5;
  localparam int PCSR_CP_LSB      = 0;
  localparam int PCSR_LDIV_LSB    = 6;
  localparam int PCSR_XPT_BIT     = 4;
  localparam int PCSR_VDIV_LSB    = 2;
  localparam int PCSR_RDIV_LSB    = 0;
  localparam int PCSR_LOCK_BIT    = 7;
  localparam int PCSR_ENABLE_BIT  = 7;
  localparam int PCSR_MANUAL_BIT  = 6;
  localparam int PCSR_SYNC_STAGES = 2;
  // wishbone slave states
  typedef enum logic [1:0] {
    PCSR_IDLE = 2'b01,
    PCSR_ACK  = 2'b10
  } pcsr_bus_e;
endpackage
`default_nettype wire

// >>> verilog/pcsr_regs.sv
// top: wishbone register slice for the pll configuration and status of the converter
//
// Summary of operation
// - loop filter bandwidth, bits 7:5 of loop settings, resets 111.
// - charge pump setting, bits 4:0 of loop settings, resets 00111.
// - logic clock ratio bits 7:6 picks divide 2,4,8,16; resets 11.
// - divider bit 4 enables loop divider crosspoint control; resets 0.
// - oscillator output ratio bits 3:2 gives 1,2,4,4; resets 10.
// - loop divider bits 1:0 gives 2,4,8,16; resets 01.
// - lock status bit 7 reads 1 when multiplier output stable; read only.
// - tuning voltage level is a 4-bit read only unsigned readback.
// - when locked, higher band lowers voltage readback, lower band raises it.
// - selected band appears as 6-bit read only field, resets zero.
// - in-phase full scale code: low byte plus bits 1:0 of next.
// - full scale code resets to 1F9, low byte F9, high bits 01.
// - loop settings reset E7, divider settings reset C9.
// - separate enable bit, reset 0, switches the clock multiplier on.
// - manual band mode: 6-bit band field selects lowest to highest band.
`default_nettype none
module pcsr_regs
  import pcsr_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [PCSR_ADDR_W+1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // readbacks from the analog pll
  input  wire logic                  pll_lock_raw,
  input  wire logic [3:0]            tuning_voltage_raw,
  input  wire logic [5:0]            band_raw,
  // settings to the analog pll
  output logic                       pll_enable,
  output logic                       manual_band_mode,
  output logic      [5:0]            manual_band,
  output logic      [2:0]            loop_filter_bandwidth,
  output logic      [4:0]            charge_pump_setting,
  output logic      [4:0]            logic_clock_divide,
  output logic                       crosspoint_enable,
  output logic      [2:0]            oscillator_divide,
  output logic      [4:0]            loop_divide,
  output logic      [9:0]            inphase_fullscale
);
  import pcsr_pkg::*;

  // ratio decode, shared by the two power-of-two dividers
  function automatic logic [4:0] pcsr_pow2_ratio(input logic [1:0] code);
    logic [4:0] r;
    r = 5'h02 << code;
    return r;
  endfunction

  function automatic logic [2:0] pcsr_vco_ratio(input logic [1:0] code);
    logic [2:0] r;
    case (code)
      2'h0:    r = 3'h1;
      2'h1:    r = 3'h2;
      default: r = 3'h4;
    endcase
    return r;
  endfunction

  pcsr_sync_if sif ();

  assign sif.raw_lock    = pll_lock_raw;
  assign sif.raw_voltage = tuning_voltage_raw;
  assign sif.raw_band    = band_raw;

  pcsr_status_sync pcsr_status_sync_i (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  logic [7:0] loop_settings_reg;
  logic [7:0] divider_settings_reg;
  logic [7:0] fs_low;
  logic [7:0] fs_high;
  logic [7:0] pll_ctrl;
  pcsr_bus_e  state;
  pcsr_bus_e  next_state;

  // address decode
  wire             req       = wb_cyc_i && wb_stb_i;
  wire [1:0]       adr_low   = wb_adr_i[1:0];
  wire [PCSR_ADDR_W-1:0] idx = wb_adr_i[PCSR_ADDR_W+1:2];
  wire             hit_loop  = (idx == PCSR_IDX_LOOP);
  wire             hit_div   = (idx == PCSR_IDX_DIV);
  wire             hit_lock  = (idx == PCSR_IDX_LOCK);
  wire             hit_band  = (idx == PCSR_IDX_BAND);
  wire             hit_fslo  = (idx == PCSR_IDX_FS_LOW);
  wire             hit_fshi  = (idx == PCSR_IDX_FS_HIGH);
  wire             hit_ctrl  = (idx == PCSR_IDX_CTRL);
  wire             mapped    = (hit_loop || hit_div || hit_lock || hit_band ||
                                hit_fslo || hit_fshi || hit_ctrl) && (adr_low == 2'h0);
  wire             take      = req && (state == PCSR_IDLE);
  // writes land only on lane 0; status registers ignore writes
  wire             wr        = take && mapped && wb_we_i && wb_sel_i[0];
  wire [7:0]       wbyte     = wb_dat_i[7:0];

  // status only carries meaning while the multiplier runs
  wire             lock_live = pll_ctrl[PCSR_ENABLE_BIT] && sif.lock;
  // voltage is passed as sampled; its direction versus band is the analog loop's
  wire [7:0]       lock_byte = {lock_live, 3'h0,
                                pll_ctrl[PCSR_ENABLE_BIT] ? sif.voltage : 4'h0};
  wire [7:0]       band_byte = {2'h0, pll_ctrl[PCSR_ENABLE_BIT] ? sif.band : 6'h00};

  wire [7:0]       rd_byte   = hit_loop ? loop_settings_reg    :
                               hit_div  ? divider_settings_reg :
                               hit_lock ? lock_byte            :
                               hit_band ? band_byte            :
                               hit_fslo ? fs_low               :
                               hit_fshi ? fs_high              :
                               hit_ctrl ? pll_ctrl             : 8'h00;

  always_comb begin
    case (state)
      PCSR_IDLE: next_state = req ? PCSR_ACK : PCSR_IDLE;
      PCSR_ACK:  next_state = PCSR_IDLE;
      default:   next_state = PCSR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= PCSR_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      wb_ack_o <= take && mapped;
      wb_err_o <= take && !mapped;
      wb_dat_o <= (take && mapped && !wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_settings_reg    <= PCSR_RST_LOOP;
      divider_settings_reg <= PCSR_RST_DIV;
      fs_low               <= PCSR_RST_FS_LOW;
      fs_high              <= PCSR_RST_FS_HIGH;
      pll_ctrl             <= PCSR_RST_CTRL;
    end else if (wr) begin
      if (hit_loop) begin
        loop_settings_reg <= wbyte;
      end
      if (hit_div) begin
        // bit 5 has no function and stays as written
        divider_settings_reg <= wbyte;
      end
      if (hit_fslo) begin
        fs_low <= wbyte;
      end
      if (hit_fshi) begin
        fs_high <= wbyte;
      end
      if (hit_ctrl) begin
        pll_ctrl <= wbyte;
      end
    end
  end

  // analog settings, registered so each output leaves a flip-flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_enable            <= 1'b0;
      manual_band_mode      <= 1'b0;
      manual_band           <= 6'h00;
      loop_filter_bandwidth <= 3'h7;
      charge_pump_setting   <= 5'h07;
      logic_clock_divide    <= 5'h10;
      crosspoint_enable     <= 1'b0;
      oscillator_divide     <= 3'h4;
      loop_divide           <= 5'h04;
      inphase_fullscale     <= 10'h1F9;
    end else begin
      pll_enable            <= pll_ctrl[PCSR_ENABLE_BIT];
      manual_band_mode      <= pll_ctrl[PCSR_MANUAL_BIT];
      manual_band           <= pll_ctrl[5:0];
      loop_filter_bandwidth <= loop_settings_reg[PCSR_BW_LSB +: 3];
      charge_pump_setting   <= loop_settings_reg[PCSR_CP_LSB +: 5];
      // software must keep reference / ratio under 75 MHz; not checked here
      logic_clock_divide    <= pcsr_pow2_ratio(divider_settings_reg[PCSR_LDIV_LSB +: 2]);
      crosspoint_enable     <= divider_settings_reg[PCSR_XPT_BIT];
      oscillator_divide     <= pcsr_vco_ratio(divider_settings_reg[PCSR_VDIV_LSB +: 2]);
      loop_divide           <= pcsr_pow2_ratio(divider_settings_reg[PCSR_RDIV_LSB +: 2]);
      inphase_fullscale     <= {fs_high[1:0], fs_low};
    end
  end
endmodule
`default_nettype wire

// >>> verilog/pcsr_status_sync.sv
// module: two-stage synchroniser with stability check for the pll readbacks
`default_nettype none
module pcsr_status_sync
  import pcsr_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // readbacks
  pcsr_sync_if.sync  sif
);
  localparam int W = 11;
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] held;
  wire  [W-1:0] raw_bus = {sif.raw_lock, sif.raw_voltage, sif.raw_band};
  // a multi-bit word may skew across bits; accept only when two samples agree
  wire          stable  = (stage2 == stage3);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      held   <= '0;
    end else begin
      stage1 <= raw_bus;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stable) begin
        held <= stage3;
      end
    end
  end

  assign sif.lock    = held[10];
  assign sif.voltage = held[9:6];
  assign sif.band    = held[5:0];
endmodule
`default_nettype wire

// >>> verilog/pcsr_sync_if.sv
// interface: raw pll readbacks entering the synchroniser, and their settled copies
`default_nettype none
interface pcsr_sync_if;
  logic       raw_lock;
  logic [3:0] raw_voltage;
  logic [5:0] raw_band;
  logic       lock;
  logic [3:0] voltage;
  logic [5:0] band;
  modport sync (input raw_lock, raw_voltage, raw_band, output lock, voltage, band);
  modport regs (output raw_lock, raw_voltage, raw_band, input lock, voltage, band);
endinterface
`default_nettype wire
